// ### logic/hid_wake_ctrl.sv
`timescale 1ns/1ps
// Wake-override, device recognition and power wake control with a Wishbone slave
module hid_wake_ctrl #(
	parameter int unsigned TICK_CYCLES     = hid_wake_pkg::TICK_CYCLES,
	parameter int unsigned FS_WINDOW_TICKS = hid_wake_pkg::FS_WINDOW_TICKS,
	parameter int unsigned LOW_LOAD_TICKS  = hid_wake_pkg::LOW_LOAD_TICKS,
	parameter int unsigned DISCHARGE_TICKS = hid_wake_pkg::DISCHARGE_TICKS
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic        wb_we_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Mode select pins
	input  wire logic        mode_select_pin_a_i,
	input  wire logic        mode_select_pin_b_i,
	input  wire logic        mode_select_pin_c_i,
	input  wire logic        current_limit_select_i,
	// Data line level comparators
	input  wire logic        dp_high_i,
	input  wire logic        dm_high_i,
	// Load current comparators
	input  wire logic        load_below_45ma_i,
	input  wire logic        load_at_limit_i,
	// Port control
	output logic             status_n_o,
	output logic             discharge_o,
	output logic             low_limit_o,
	output logic             high_limit_o,
	output logic             auto_charge_detect_mode_o,
	output logic             hold_link_o
);

	generate
		if (TICK_CYCLES < 2 || FS_WINDOW_TICKS < 1 || LOW_LOAD_TICKS < 1 ||
			DISCHARGE_TICKS < 1) begin : g_bad_param
			$error("hid_wake_ctrl timing parameters out of range");
		end
	endgenerate

	localparam int unsigned DW = $clog2(TICK_CYCLES);
	localparam logic [DW-1:0] DIV_LAST = DW'(TICK_CYCLES - 1);

	hid_wake_pkg::pins_t       pins;
	hid_wake_pkg::det_state_t  det_d;
	hid_wake_pkg::det_state_t  det_q;
	hid_wake_pkg::pw_state_t   pw_d;
	hid_wake_pkg::pw_state_t   pw_q;
	hid_wake_pkg::port_ctrl_t  ctl_d;
	hid_wake_pkg::port_ctrl_t  ctl_q;

	logic [DW-1:0] div_d;
	logic [DW-1:0] div_q;
	logic          tick_d;
	logic          tick_q;
	logic [2:0]    mode_d;
	logic [2:0]    mode_q;
	logic          ovr_d;
	logic          ovr_q;
	logic          mdis_d;
	logic          mdis_q;
	logic [1:0]    ctrl_d;
	logic [1:0]    ctrl_q;
	logic [31:0]   rdat_d;
	logic [31:0]   rdat_q;
	logic          ack_d;
	logic          ack_q;
	logic          fs_done;
	logic          low_done;
	logic          dis_done;
	logic          fs_run;
	logic          low_run;
	logic          dis_run;
	logic          pw_en;
	logic          wake_dev;

	// Pins come from outside the clock domain
	pin_sync #(
		.WIDTH ($bits(hid_wake_pkg::pins_t))
	) u_sync (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.async_i ({mode_select_pin_a_i, mode_select_pin_b_i, mode_select_pin_c_i,
			current_limit_select_i, dp_high_i, dm_high_i, load_below_45ma_i,
			load_at_limit_i}),
		.sync_o  (pins)
	);

	// Slow tick divider, one-cycle enable per tick
	always_comb begin
		tick_d = 1'b0;
		div_d  = div_q + DW'(1);
		if (div_q == DIV_LAST) begin
			div_d  = '0;
			tick_d = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div_q  <= '0;
			tick_q <= 1'b0;
		end else begin
			div_q  <= div_d;
			tick_q <= tick_d;
		end
	end

	// Timers share one tick; each restarts when its run term drops
	tick_timer #(
		.LIMIT (FS_WINDOW_TICKS)
	) u_fs_timer (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.run_i  (fs_run),
		.tick_i (tick_q),
		.done_o (fs_done)
	);

	tick_timer #(
		.LIMIT (LOW_LOAD_TICKS)
	) u_low_timer (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.run_i  (low_run),
		.tick_i (tick_q),
		.done_o (low_done)
	);

	tick_timer #(
		.LIMIT (DISCHARGE_TICKS)
	) u_dis_timer (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.run_i  (dis_run),
		.tick_i (tick_q),
		.done_o (dis_done)
	);

	// Timer run terms
	assign fs_run   = (det_q == hid_wake_pkg::DET_FS_CAND) && pins.dp &&
		ctrl_q[hid_wake_pkg::CTRL_S0_BIT];
	assign low_run  = (pw_q == hid_wake_pkg::PW_CHARGING) && pins.low_cur;
	assign dis_run  = (pw_q == hid_wake_pkg::PW_DISCHG) || mdis_q;
	assign pw_en    = ({pins.mode, pins.sel} == hid_wake_pkg::PW_SETTING) &&
		!ctrl_q[hid_wake_pkg::CTRL_PW_DIS_BIT];
	assign wake_dev = (det_q == hid_wake_pkg::DET_LS) ||
		(det_q == hid_wake_pkg::DET_FS_OK);

	// Mode tracking, wake override and mode-change discharge
	always_comb begin
		mode_d = pins.mode;
		ovr_d  = ovr_q;
		mdis_d = mdis_q && !dis_done;
		if (pins.mode != mode_q) begin
			// Select input is not part of this decision
			if (pins.mode == hid_wake_pkg::MODE_AUTO) begin
				ovr_d = hid_wake_pkg::is_override_src(mode_q);
			end else begin
				ovr_d = 1'b0;
			end
			// A split 110 to 011 move may pass through 111 and is served as such
			if (mode_q == hid_wake_pkg::MODE_STD1_B &&
				pins.mode == hid_wake_pkg::MODE_CHG_STD2) begin
				mdis_d = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_q <= 3'h0;
			ovr_q  <= 1'b0;
			mdis_q <= 1'b0;
		end else begin
			mode_q <= mode_d;
			ovr_q  <= ovr_d;
			mdis_q <= mdis_d;
		end
	end

	// Attached device classification, frozen outside downstream settings
	always_comb begin
		det_d = det_q;
		if (hid_wake_pkg::is_downstream(pins.mode)) begin
			case (det_q)
				hid_wake_pkg::DET_NONE: begin
					if (pins.dm && !pins.dp) begin
						det_d = hid_wake_pkg::DET_LS;
					end else if (pins.dp && !pins.dm) begin
						det_d = hid_wake_pkg::DET_FS_CAND;
					end
				end
				hid_wake_pkg::DET_LS: begin
					if (!pins.dm && !pins.dp) begin
						det_d = hid_wake_pkg::DET_NONE;
					end
				end
				hid_wake_pkg::DET_FS_CAND: begin
					if (!pins.dp) begin
						det_d = hid_wake_pkg::DET_HS;
					end else if (fs_done) begin
						det_d = hid_wake_pkg::DET_FS_OK;
					end
				end
				hid_wake_pkg::DET_FS_OK: begin
					// Idle full speed has D+ high; both low means unplugged
					if (!pins.dp && !pins.dm) begin
						det_d = hid_wake_pkg::DET_NONE;
					end
				end
				hid_wake_pkg::DET_HS: begin
					// Held as high speed until D- high with D+ low shows a low-speed connect
					if (pins.dm && !pins.dp) begin
						det_d = hid_wake_pkg::DET_LS;
					end
				end
				default: det_d = hid_wake_pkg::DET_NONE;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			det_q <= hid_wake_pkg::DET_NONE;
		end else begin
			det_q <= det_d;
		end
	end

	// Power wake sequence
	always_comb begin
		pw_d = pw_q;
		case (pw_q)
			hid_wake_pkg::PW_OFF: begin
				if (pw_en) begin
					pw_d = hid_wake_pkg::PW_CHARGING;
				end
			end
			hid_wake_pkg::PW_CHARGING: begin
				if (!pw_en) begin
					pw_d = hid_wake_pkg::PW_OFF;
				end else if (low_done) begin
					pw_d = hid_wake_pkg::PW_LOW;
				end
			end
			hid_wake_pkg::PW_LOW: begin
				if (!pw_en) begin
					pw_d = hid_wake_pkg::PW_OFF;
				end else if (pins.lim_hit) begin
					pw_d = hid_wake_pkg::PW_DISCHG;
				end
			end
			hid_wake_pkg::PW_DISCHG: begin
				if (!pw_en) begin
					pw_d = hid_wake_pkg::PW_OFF;
				end else if (dis_done) begin
					pw_d = hid_wake_pkg::PW_CHARGING;
				end
			end
			default: pw_d = hid_wake_pkg::PW_OFF;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pw_q <= hid_wake_pkg::PW_OFF;
		end else begin
			pw_q <= pw_d;
		end
	end

	// Port control outputs, all registered
	always_comb begin
		ctl_d.status_n    = !((pw_q == hid_wake_pkg::PW_CHARGING) ||
			(pw_q == hid_wake_pkg::PW_DISCHG));
		ctl_d.discharge   = (pw_q == hid_wake_pkg::PW_DISCHG) || mdis_q;
		ctl_d.low_limit   = (pw_q == hid_wake_pkg::PW_LOW);
		ctl_d.high_limit  = (pw_q == hid_wake_pkg::PW_CHARGING);
		ctl_d.hold_link   = ovr_q && wake_dev;
		// Auto detection would disturb the wake path, so it waits while held
		ctl_d.auto_detect = (mode_q == hid_wake_pkg::MODE_AUTO) && !(ovr_q && wake_dev);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctl_q <= '{status_n: 1'b1, default: 1'b0};
		end else begin
			ctl_q <= ctl_d;
		end
	end

	// Wishbone slave: one wait state, writes land on the edge the master sees ack
	always_comb begin
		ack_d  = wb_cyc_i && wb_stb_i && !ack_q;
		ctrl_d = ctrl_q;
		rdat_d = 32'h0000_0000;
		if (ack_q && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] &&
			wb_adr_i == hid_wake_pkg::REG_CTRL_ADDR) begin
			ctrl_d = wb_dat_i[1:0];
		end
		if (ack_d) begin
			case (wb_adr_i)
				hid_wake_pkg::REG_CTRL_ADDR: begin
					rdat_d = {30'h0000_0000, ctrl_q};
				end
				hid_wake_pkg::REG_STAT_ADDR: begin
					rdat_d = {13'h0000, pins.dm, pins.dp, pins.sel, mode_q,
						ctl_q.hold_link, pw_q, 3'h0, det_q};
				end
				default: rdat_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q <= hid_wake_pkg::CTRL_RESET;
			rdat_q <= 32'h0000_0000;
			ack_q  <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			rdat_q <= rdat_d;
			ack_q  <= ack_d;
		end
	end

	assign wb_dat_o                  = rdat_q;
	assign wb_ack_o                  = ack_q;
	assign status_n_o                = ctl_q.status_n;
	assign discharge_o               = ctl_q.discharge;
	assign low_limit_o               = ctl_q.low_limit;
	assign high_limit_o              = ctl_q.high_limit;
	assign auto_charge_detect_mode_o = ctl_q.auto_detect;
	assign hold_link_o               = ctl_q.hold_link;

endmodule // hid_wake_ctrl

// ### logic/hid_wake_pkg.sv
// Summary of operation
// - Mode pins 111 to 011 apply wake override, keeping HID sleep-wake support.
// - Mode pins 010 to 011 apply the same wake override.
// - No override for 110 to 011; a transient 111 is entered and discharges output.
// - Override decision uses mode pins only; current-limit-select is ignored.
// - Data-line levels watched only while pins select a standard or charging port.
// - Both lines low: none; D- high only: low speed; D+ high only: full-speed candidate.
// - D+ falling after full-speed connect marks high speed, not wake-capable.
// - Full speed recognized after 60 s connected with D+ high in S0.
// - After wake, mode pins may return any time; device imposes no deadline.
// - Power wake enabled only for control setting 0011, deep-sleep charging.
// - Power wake active with load charging drives status output low.
// - Current below 45 mA over 15 s selects 55 mA limit, releases status high.
// - In low-power state a load hitting the 55 mA limit asserts status low.
// - After asserting status on new load, discharge port output over 2 s.
// - After that discharge, port power returns on the high current-limit setting.
package hid_wake_pkg;

	// Timebase
	localparam int unsigned CLK_PERIOD_NS   = 20;
	localparam int unsigned TICK_PERIOD_NS  = 1_000_000;
	localparam int unsigned TICK_CYCLES     = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int unsigned TICKS_PER_S     = 1_000_000_000 / TICK_PERIOD_NS;

	// Times in seconds and their tick counts
	localparam int unsigned FS_WINDOW_S     = 60;
	localparam int unsigned LOW_LOAD_S      = 15;
	localparam int unsigned DISCHARGE_S     = 2;
	localparam int unsigned FS_WINDOW_TICKS = FS_WINDOW_S * TICKS_PER_S;
	localparam int unsigned LOW_LOAD_TICKS  = LOW_LOAD_S * TICKS_PER_S;
	localparam int unsigned DISCHARGE_TICKS = DISCHARGE_S * TICKS_PER_S + 1;

	// Mode pin codes, pin a in the top bit
	localparam logic [2:0] MODE_AUTO        = 3'h3;
	localparam logic [2:0] MODE_CHG_STD2    = 3'h7;
	localparam logic [2:0] MODE_STD1_A      = 3'h2;
	localparam logic [2:0] MODE_STD1_B      = 3'h6;
	localparam logic [3:0] PW_SETTING       = 4'h3;

	// Register map
	localparam int unsigned ADDR_W          = 8;
	localparam logic [7:0]  REG_CTRL_ADDR   = 8'h00;
	localparam logic [7:0]  REG_STAT_ADDR   = 8'h04;
	localparam int unsigned CTRL_S0_BIT     = 0;
	localparam int unsigned CTRL_PW_DIS_BIT = 1;
	localparam logic [1:0]  CTRL_RESET      = 2'h0;

	// Attached device class
	typedef enum logic [4:0] {
		DET_NONE    = 5'h01,
		DET_LS      = 5'h02,
		DET_FS_CAND = 5'h04,
		DET_FS_OK   = 5'h08,
		DET_HS      = 5'h10
	} det_state_t;

	// Power wake states
	typedef enum logic [3:0] {
		PW_OFF      = 4'h1,
		PW_CHARGING = 4'h2,
		PW_LOW      = 4'h4,
		PW_DISCHG   = 4'h8
	} pw_state_t;

	// Synchronised pin bundle
	typedef struct packed {
		logic [2:0] mode;
		logic       sel;
		logic       dp;
		logic       dm;
		logic       low_cur;
		logic       lim_hit;
	} pins_t;

	// Port control outputs
	typedef struct packed {
		logic status_n;
		logic discharge;
		logic low_limit;
		logic high_limit;
		logic auto_detect;
		logic hold_link;
	} port_ctrl_t;

	// Standard or charging downstream setting
	function automatic logic is_downstream(input logic [2:0] m);
		return (m == MODE_CHG_STD2) || (m == MODE_STD1_A) || (m == MODE_STD1_B);
	endfunction

	// Source settings whose move to auto mode is overridden
	function automatic logic is_override_src(input logic [2:0] m);
		return (m == MODE_CHG_STD2) || (m == MODE_STD1_A);
	endfunction

endpackage

// ### logic/pin_sync.sv
`timescale 1ns/1ps
// Three-stage synchroniser; output follows once stages two and three agree
module pin_sync #(
	parameter int unsigned WIDTH = 8
) (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	// Pins and synchronised levels
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;
	logic [WIDTH-1:0] out_d;
	logic [WIDTH-1:0] out_q;

	// Per bit: a level counts only when two stable stages match
	always_comb begin
		for (int i = 0; i < WIDTH; i++) begin
			out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : out_q[i];
		end
	end

	// Stage one is read only by stage two
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_q  <= '0;
			s2_q  <= '0;
			s3_q  <= '0;
			out_q <= '0;
		end else begin
			s1_q  <= async_i;
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			out_q <= out_d;
		end
	end

	assign sync_o = out_q;

endmodule // pin_sync

// ### logic/tick_timer.sv
`timescale 1ns/1ps
// Counts slow ticks while run is high; done holds until run drops
module tick_timer #(
	parameter int unsigned LIMIT = 15
) (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Control
	input  wire logic run_i,
	input  wire logic tick_i,
	output logic      done_o
);
	localparam int unsigned CW = $clog2(LIMIT + 1);
	localparam logic [CW-1:0] LAST = CW'(LIMIT);

	logic [CW-1:0] cnt_d;
	logic [CW-1:0] cnt_q;
	logic          done_d;
	logic          done_q;

	generate
		if (LIMIT < 1) begin : g_bad_limit
			$error("tick_timer LIMIT must be at least 1");
		end
	endgenerate

	// Dropping run clears the count, so any break restarts the full wait
	always_comb begin
		cnt_d  = cnt_q;
		done_d = done_q;
		if (!run_i) begin
			cnt_d  = '0;
			done_d = 1'b0;
		end else if (tick_i && !done_q) begin
			cnt_d  = cnt_q + CW'(1);
			done_d = (cnt_q + CW'(1)) == LAST;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q  <= '0;
			done_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			done_q <= done_d;
		end
	end

	assign done_o = done_q;

endmodule // tick_timer

// ### verification/hid_wake_monitor.sv
`timescale 1ns/1ps
// Port checks of wake override and power wake sequencing
module hid_wake_monitor #(
	parameter int unsigned TICK_CYCLES     = 4,
	parameter int unsigned LOW_LOAD_TICKS  = 5,
	parameter int unsigned DISCHARGE_TICKS = 3
) (
	// Clock, reset and bus
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_ack_o,
	// Pins
	input wire logic mode_select_pin_a_i,
	input wire logic mode_select_pin_b_i,
	input wire logic mode_select_pin_c_i,
	input wire logic current_limit_select_i,
	input wire logic load_below_45ma_i,
	// Port control
	input wire logic status_n_o,
	input wire logic discharge_o,
	input wire logic low_limit_o,
	input wire logic high_limit_o,
	input wire logic auto_charge_detect_mode_o,
	input wire logic hold_link_o
);
	// Timers tick coarsely, so one tick of slack is allowed
	localparam int unsigned LOW_MIN = (LOW_LOAD_TICKS - 1) * TICK_CYCLES;
	localparam int unsigned DIS_MIN = (DISCHARGE_TICKS - 1) * TICK_CYCLES;
	logic [15:0] low_q, low_d, dis_q, dis_d, off_q, off_d, auto_q, auto_d;
	logic [2:0]  mode;
	assign mode = {mode_select_pin_a_i, mode_select_pin_b_i, mode_select_pin_c_i};
	// Saturating run lengths; saturation avoids a false wrap on long runs
	always_comb begin
		low_d  = (rst_i || !load_below_45ma_i) ? 16'h0000 : low_q + {15'h0000, ~&low_q};
		dis_d  = (rst_i || !discharge_o) ? 16'h0000 : dis_q + {15'h0000, ~&dis_q};
		off_d  = (rst_i || {mode, current_limit_select_i} == 4'h3) ? 16'h0000
			: off_q + {15'h0000, ~&off_q};
		auto_d = (rst_i || mode != 3'h3) ? 16'h0000 : auto_q + {15'h0000, ~&auto_q};
	end
	always_ff @(posedge clk_i) begin
		low_q  <= low_d;
		dis_q  <= dis_d;
		off_q  <= off_d;
		auto_q <= auto_d;
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	lowlim_status_a: assert property (low_limit_o |-> status_n_o && !high_limit_o)
		else $error("low limit while status asserted");
	lowload_wait_a: assert property ($rose(low_limit_o) |-> low_q >= LOW_MIN)
		else $error("low limit taken too early");
	load_alert_a: assert property ($fell(status_n_o) && $past(low_limit_o)
		|-> discharge_o && !low_limit_o) else $error("no discharge on new load");
	discharge_len_a: assert property ($fell(discharge_o) |-> dis_q >= DIS_MIN)
		else $error("discharge too short");
	high_return_a: assert property ($fell(discharge_o) && !status_n_o
		|-> high_limit_o && !low_limit_o) else $error("high limit missing after discharge");
	wake_setting_a: assert property (!status_n_o |-> off_q < 16'h0008)
		else $error("status asserted outside wake setting");
	hold_auto_a: assert property (hold_link_o |-> !auto_charge_detect_mode_o)
		else $error("auto mode during hold");
	auto_source_a: assert property ($rose(hold_link_o) ||
		$rose(auto_charge_detect_mode_o) |-> auto_q >= 16'h0003) else $error("bad auto source");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
endmodule // hid_wake_monitor

bind hid_wake_ctrl hid_wake_monitor #(
	.TICK_CYCLES(TICK_CYCLES), .LOW_LOAD_TICKS(LOW_LOAD_TICKS), .DISCHARGE_TICKS(DISCHARGE_TICKS)
) u_mon (
	.clk_i(clk_i), .rst_i(rst_i), .wb_ack_o(wb_ack_o),
	.mode_select_pin_a_i(mode_select_pin_a_i), .mode_select_pin_b_i(mode_select_pin_b_i),
	.mode_select_pin_c_i(mode_select_pin_c_i), .current_limit_select_i(current_limit_select_i),
	.load_below_45ma_i(load_below_45ma_i), .status_n_o(status_n_o), .discharge_o(discharge_o),
	.low_limit_o(low_limit_o), .high_limit_o(high_limit_o), .hold_link_o(hold_link_o),
	.auto_charge_detect_mode_o(auto_charge_detect_mode_o)
);

// ### verification/usb_hid_wake_and_load_detect_test.sv
`timescale 1ns/1ps
// Self-checking bench of the wake override and power wake block
module usb_hid_wake_and_load_detect_test;
	localparam int TICK = 4, FSW = 6, LOW = 5, DIS = 3;
	localparam int DIS_MIN = (DIS - 1) * TICK;
	localparam logic [7:0] CTRL = hid_wake_pkg::REG_CTRL_ADDR;
	localparam logic [7:0] STAT = hid_wake_pkg::REG_STAT_ADDR;
	logic        clk_i, rst_i, we, cyc, lsel, ack, dp, dm, below, at_lim;
	logic        status_n, dis, lo_lim, hi_lim, auto_m, hold;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [2:0]  mode;
	logic [1:0]  kind, load;
	logic [31:0] wdat, dat_o, rd, seed;
	int          n_fail, tests_run, n;

	hid_wake_ctrl #(.TICK_CYCLES(TICK), .FS_WINDOW_TICKS(FSW), .LOW_LOAD_TICKS(LOW),
		.DISCHARGE_TICKS(DIS)) u_dut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
		.wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.mode_select_pin_a_i(mode[2]), .mode_select_pin_b_i(mode[1]),
		.mode_select_pin_c_i(mode[0]), .current_limit_select_i(lsel), .dp_high_i(dp),
		.dm_high_i(dm), .load_below_45ma_i(below), .load_at_limit_i(at_lim),
		.status_n_o(status_n), .discharge_o(dis), .low_limit_o(lo_lim), .high_limit_o(hi_lim),
		.auto_charge_detect_mode_o(auto_m), .hold_link_o(hold));
	usb_port_model u_port (.clk_i(clk_i), .kind_i(kind), .load_i(load), .discharge_i(dis),
		.low_limit_i(lo_lim), .dp_high_o(dp), .dm_high_o(dm), .load_below_45ma_o(below),
		.load_at_limit_o(at_lim));

	// 50 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	// Expectations
	function automatic logic exp_hold(input logic [2:0] f, input logic [2:0] t, input logic w);
		return w && t == 3'h3 && (f == 3'h7 || f == 3'h2);
	endfunction
	function automatic logic exp_pw(input logic [3:0] s);
		return s == 4'h3;
	endfunction
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic wt(input int c);
		repeat (c) @(posedge clk_i);
	endtask
	// Classic cycle: hold everything until ack, then release for a cycle
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		int k;
		k = 0;
		cyc  <= 1'b1;
		we   <= w;
		adr  <= a;
		wdat <= d;
		sel  <= s;
		do begin
			@(posedge clk_i);
			k++;
		end while (ack !== 1'b1);
		rd = dat_o;
		cyc <= 1'b0;
		we  <= 1'b0;
		chk(32'(k < 16), 32'h0000_0001);
		@(posedge clk_i);
	endtask
	task automatic det_chk(input logic [4:0] e);
		wb(1'b0, STAT, 32'h0000_0000, 4'hf);
		chk({27'h000_0000, rd[4:0]}, {27'h000_0000, e});
	endtask
	// Attach, classify, move to auto mode, then unplug while frozen
	task automatic ovr(input logic [2:0] f, input logic [1:0] k, input logic [4:0] d);
		logic w;
		w = (k == 2'h1) || (k == 2'h2);
		seed = lfsr(seed);
		lsel <= seed[0];
		kind <= k;
		mode <= f;
		wt(50);
		det_chk(d);
		mode <= 3'h3;
		wt(100);
		chk(32'(hold), 32'(exp_hold(f, 3'h3, w)));
		chk(32'(auto_m), 32'(!exp_hold(f, 3'h3, w)));
		kind <= 2'h0;
		wt(12);
		det_chk(d);
		mode <= 3'h7;
		wt(12);
		$display("override case done");
	endtask

	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Watchdog
	initial begin
		wt(30000);
		n_fail++;
		$display("BAD %0t watchdog expired", $time);
		print_verdict();
	end

	// Main sequence
	initial begin
		n_fail = 0;
		tests_run = 0;
		seed = 32'h24a0_e841;
		{rst_i, cyc, we, lsel} = 4'h8;
		{adr, wdat, sel} = '0;
		mode = 3'h7;
		kind = 2'h0;
		load = 2'h1;
		wt(2);
		rst_i <= 1'b0;
		wt(1);
		wb(1'b0, CTRL, 32'h0000_0000, 4'hf);
		chk(rd, 32'(hid_wake_pkg::CTRL_RESET));
		kind <= 2'h2;
		wt(50);
		det_chk(hid_wake_pkg::DET_FS_CAND);
		kind <= 2'h1;
		wt(12);
		kind <= 2'h0;
		wt(12);
		wb(1'b1, 8'h08, 32'hffff_ffff, 4'hf);
		wb(1'b0, 8'h08, 32'h0000_0000, 4'hf);
		chk(rd, 32'h0000_0000);
		wb(1'b1, CTRL, 32'hffff_fffd, 4'hf);
		wb(1'b1, CTRL, 32'h0000_0000, 4'he);
		wb(1'b0, CTRL, 32'h0000_0000, 4'hf);
		chk(rd, 32'h0000_0001);
		$display("register test done");
		ovr(3'h7, 2'h0, hid_wake_pkg::DET_NONE);
		ovr(3'h7, 2'h1, hid_wake_pkg::DET_LS);
		ovr(3'h2, 2'h1, hid_wake_pkg::DET_LS);
		ovr(3'h6, 2'h1, hid_wake_pkg::DET_LS);
		ovr(3'h7, 2'h2, hid_wake_pkg::DET_FS_OK);
		ovr(3'h2, 2'h3, hid_wake_pkg::DET_HS);
		mode <= 3'h6;
		wt(12);
		mode <= 3'h7;
		n = 0;
		repeat (30) begin
			@(posedge clk_i);
			if (dis === 1'b1)
				n++;
		end
		chk(32'(n >= DIS_MIN), 32'h0000_0001);
		$display("transient test done");
		mode <= 3'h1;
		lsel <= 1'b1;
		wt(12);
		chk(32'(status_n), 32'(!exp_pw(4'h3)));
		load <= 2'h0;
		wt(12);
		load <= 2'h1;
		wt(4);
		load <= 2'h0;
		wt(12);
		chk(32'(status_n), 32'h0000_0000);
		wt(30);
		chk(32'({status_n, lo_lim}), 32'h0000_0003);
		load <= 2'h2;
		n = 0;
		while (dis !== 1'b1 && n < 20) begin
			@(posedge clk_i);
			n++;
		end
		chk(32'(status_n), 32'h0000_0000);
		n = 0;
		while (dis === 1'b1 && n < 40) begin
			@(posedge clk_i);
			n++;
		end
		chk(32'(n >= DIS_MIN), 32'h0000_0001);
		wt(2);
		chk(32'({hi_lim, lo_lim}), 32'h0000_0002);
		load <= 2'h1;
		wb(1'b1, CTRL, 32'h0000_0003, 4'hf);
		wt(10);
		chk(32'(status_n), 32'h0000_0001);
		wb(1'b1, CTRL, 32'h0000_0001, 4'hf);
		for (int i = 0; i < 12; i++) begin
			seed = lfsr(seed);
			mode <= seed[3:1];
			lsel <= seed[0];
			wt(12);
			chk(32'(status_n), 32'(!exp_pw(seed[3:0])));
		end
		$display("power wake test done");
		print_verdict();
	end
endmodule // usb_hid_wake_and_load_detect_test

// ### verification/usb_port_model.sv
`timescale 1ns/1ps
// Attached peripheral and its load current
module usb_port_model (
	// Clock and bench commands
	input  wire logic       clk_i,
	input  wire logic [1:0] kind_i,
	input  wire logic [1:0] load_i,
	// Port state from the controller
	input  wire logic       discharge_i,
	input  wire logic       low_limit_i,
	// Data lines and load comparators
	output logic            dp_high_o,
	output logic            dm_high_o,
	output logic            load_below_45ma_o,
	output logic            load_at_limit_o
);
	logic [3:0] hs_q, hs_d;
	// High-speed part drops its pull-up after a short connect
	always_comb hs_d = (kind_i == 2'h3) ? hs_q + {3'h0, hs_q != 4'hf} : 4'h0;
	always_ff @(posedge clk_i) hs_q <= hs_d;
	// Idle levels: low speed holds D-, full speed holds D+
	assign dm_high_o = (kind_i == 2'h1);
	assign dp_high_o = (kind_i == 2'h2) || (kind_i == 2'h3 && hs_q < 4'h6);
	// No current flows while the output is discharged
	assign load_below_45ma_o = discharge_i || load_i == 2'h0;
	assign load_at_limit_o = !discharge_i && low_limit_i && load_i == 2'h2;
endmodule // usb_port_model
